/* hdl/irc_handler.sv */
/*
 * Remote command handler: decodes the cyclic bits and words that the
 * network master sends into run, stop and terminal commands, and runs
 * the monitor, frequency write, instruction and error reset handshakes
 * toward the inverter core.
 * Assumes link bits, link words and core signals are on the same clock,
 * and that the master holds each request until its completion flag.
 */
// Our own choices: the address-and-strobe port and the placing of the registers.
//
// Function
// - Forward bit on starts forward, off stops.
// - Reverse bit on starts reverse, off stops.
// - Both run bits on means stop.
// - Output stop bit asserts output shutoff.
// - Seven speed/jog/select bits drive assigned functions.
// - Self-hold and reset bits drive assigned functions.
// - Run and stop bits cannot be reassigned.
// - Command source setting masks some assignable bits.
// - Monitor request loads words, then sets valid.
// - Monitor words refresh while request stays on.
// - Volatile write stores to RAM, then done.
// - Nonvolatile write with volatile bit off stores RAM and EEPROM, then done.
// - Instruction request runs all six slot codes.
// - Instruction done only after all slots executed.
// - Failed slot gets nonzero reply, zero success.
// - Error reset acts only during inverter fault.
// - Set frequency echoed while volatile bit on.
// - Extended mode zero runs one simultaneous request.
// - Bit positions given are station 1's.
// - Write done flags clear when request drops.
// - Monitoring valid clears when request drops.
// - Error status sets when protection trips.
// - Station ready sets after initial setup.
`timescale 1ns/1ps
`include "irc_params.svh"
module irc_handler #(
    parameter int SLOTS       = 6,
    parameter int WORD_W      = 16,
    parameter int MONITORS    = 6,
    parameter int ASSIGNABLE  = 9,
    parameter int FUNCS       = 16,
    parameter int INIT_CYCLES = `IRC_INIT_CYCLES
) (
    // Clock, enable and reset.
    input  wire logic                         clock,
    input  wire logic                         ce,
    input  wire logic                         resetn,
    // Register port.
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_write,
    input  wire logic                         reg_read,
    output logic      [31:0]                  reg_rdata,
    // Cyclic bits and words from the master.
    input  wire logic [31:0]                  link_bits,
    input  wire logic [WORD_W-1:0]            set_frequency_word,
    input  wire logic [SLOTS*WORD_W-1:0]      instruction_code_word,
    input  wire logic [$clog2(SLOTS)-1:0]     reply_index,
    // Cyclic flags and words to the master.
    output logic                              monitoring_valid_flag,
    output logic                              freq_volatile_done_flag,
    output logic                              freq_nonvolatile_done_flag,
    output logic                              instruction_exec_done_flag,
    output logic                              error_status_flag,
    output logic                              station_ready_flag,
    output logic      [MONITORS*WORD_W-1:0]   monitor_value_word,
    output logic      [WORD_W-1:0]            freq_echo_word,
    output logic      [WORD_W-1:0]            reply_code_word,
    // Inverter core commands.
    output logic                              forward_run,
    output logic                              reverse_run,
    output logic                              output_shutoff_function,
    output logic      [FUNCS-1:0]             terminal_function,
    output logic                              inverter_reset,
    // Inverter core monitor, storage and instruction handshakes.
    input  wire logic [MONITORS*WORD_W-1:0]   monitor_data,
    output logic      [WORD_W-1:0]            core_freq_data,
    output logic                              ram_write_req,
    input  wire logic                         ram_write_ack,
    output logic                              eeprom_write_req,
    input  wire logic                         eeprom_write_ack,
    output logic                              instr_req,
    output logic      [WORD_W-1:0]            instr_code,
    input  wire logic                         instr_ack,
    input  wire logic [WORD_W-1:0]            instr_result,
    // Inverter fault level.
    input  wire logic                         inverter_fault
);

    localparam int SW = $clog2(SLOTS);
    localparam int IW = $clog2(INIT_CYCLES + 1);

    typedef struct packed {
        logic [ASSIGNABLE-1:0]      source_mask;
        logic [7:0]                 extended;
        logic [ASSIGNABLE*4-1:0]    assign_codes;
        logic [31:0]                rdata;
        logic [31:0]                prev_bits;
        logic                       prev_fault;
        logic [2:0]                 pending;
        irc_pkg::irc_state_t        fsm;
        logic [SW-1:0]              slot;
        logic                       monitor_valid;
        logic                       ram_done;
        logic                       ee_done;
        logic                       instr_done;
        logic                       error_status;
        logic                       station_ready;
        logic [IW-1:0]              init_count;
        logic [MONITORS*WORD_W-1:0] monitor_words;
        logic [WORD_W-1:0]          freq_echo;
        logic [WORD_W-1:0]          freq_data;
        logic                       forward;
        logic                       reverse;
        logic                       shutoff;
        logic [FUNCS-1:0]           functions;
        logic                       reset_pulse;
    } irc_state_t;

    irc_state_t state;
    irc_state_t next_state;

    logic [ASSIGNABLE-1:0] assign_bits;
    logic [ASSIGNABLE-1:0] masked_bits;
    logic [FUNCS-1:0]      decoded_functions;
    logic [2:0]            request_level;
    logic [2:0]            request_rise;
    logic [2:0]            accepted;
    logic                  reply_we;
    logic [WORD_W-1:0]     reply_wdata;

    // Station 1 positions; other stations are remapped by the link layer.
    assign request_level = {link_bits[`IRC_BIT_INSTR_EXEC],
                            link_bits[`IRC_BIT_FREQ_EEPROM],
                            link_bits[`IRC_BIT_FREQ_RAM]};
    assign request_rise  = request_level
                         & ~{state.prev_bits[`IRC_BIT_INSTR_EXEC],
                            state.prev_bits[`IRC_BIT_FREQ_EEPROM],
                            state.prev_bits[`IRC_BIT_FREQ_RAM]};

    // In extended mode zero only the first of simultaneous rises is taken.
    always_comb begin
        accepted = request_rise;
        if (state.extended == `IRC_EXTENDED_RESET) begin
            if (request_rise[0]) begin
                accepted = 3'h1;
            end else if (request_rise[1]) begin
                accepted = 3'h2;
            end
        end
    end

    // Assignable bits: seven contiguous plus the self-hold and reset bits.
    assign assign_bits = {link_bits[`IRC_BIT_RESET_FUNC],
                          link_bits[`IRC_BIT_SELF_HOLD],
                          link_bits[`IRC_BIT_OUTPUT_STOP-1:`IRC_BIT_ASSIGN_FIRST]};
    assign masked_bits = assign_bits & ~state.source_mask;

    // Each assignable bit drives the function its code selects.
    logic [FUNCS-1:0] one_hot [ASSIGNABLE];
    genvar gi;
    generate
        for (gi = 0; gi < ASSIGNABLE; gi++) begin : g_assign
            always_comb begin
                one_hot[gi] = '0;
                one_hot[gi][state.assign_codes[gi*4 +: 4]] = masked_bits[gi];
            end
        end
    endgenerate

    // OR all assigned functions into the terminal function vector.
    always_comb begin
        decoded_functions = '0;
        for (int i = 0; i < ASSIGNABLE; i++) begin
            decoded_functions = decoded_functions | one_hot[i];
        end
    end

    // Reply code store, written once per executed slot.
    irc_reply_mem #(
        .DEPTH (SLOTS),
        .WIDTH (WORD_W)
    ) u_reply_mem (
        .clock  (clock),
        .ce     (ce),
        .resetn (resetn),
        .we     (reply_we),
        .waddr  (state.slot),
        .wdata  (reply_wdata),
        .raddr  (reply_index),
        .rdata  (reply_code_word)
    );

    assign reply_we    = (state.fsm == irc_pkg::IRC_INSTR_WAIT) && instr_ack;
    assign reply_wdata = instr_result;

    // Next state of the whole handler.
    always_comb begin
        next_state = state;
        next_state.prev_bits   = link_bits;
        next_state.prev_fault  = inverter_fault;
        next_state.reset_pulse = 1'b0;

        // Register writes; the fixed-assignment register ignores writes.
        if (reg_write) begin
            unique case (reg_addr)
                `IRC_ADDR_SOURCE: begin
                    next_state.source_mask = reg_wdata[ASSIGNABLE-1:0];
                end
                `IRC_ADDR_EXTENDED: begin
                    next_state.extended = reg_wdata[7:0];
                end
                `IRC_ADDR_ASSIGN_LO: begin
                    next_state.assign_codes[31:0] = reg_wdata;
                end
                `IRC_ADDR_ASSIGN_HI: begin
                    next_state.assign_codes[35:32] = reg_wdata[3:0];
                end
                default: begin
                    next_state.extended = state.extended;
                end
            endcase
        end

        // Register reads, data standing in the following cycle only.
        next_state.rdata = 32'h00000000;
        if (reg_read) begin
            unique case (reg_addr)
                `IRC_ADDR_SOURCE:    next_state.rdata[ASSIGNABLE-1:0] = state.source_mask;
                `IRC_ADDR_EXTENDED:  next_state.rdata[7:0] = state.extended;
                `IRC_ADDR_ASSIGN_LO: next_state.rdata = state.assign_codes[31:0];
                `IRC_ADDR_ASSIGN_HI: next_state.rdata[3:0] = state.assign_codes[35:32];
                `IRC_ADDR_STATUS: begin
                    next_state.rdata[2:0] = state.fsm;
                    next_state.rdata[5:3] = state.pending;
                    next_state.rdata[6]   = state.error_status;
                    next_state.rdata[7]   = state.station_ready;
                end
                default: next_state.rdata = 32'h00000000;
            endcase
        end

        // Run commands; both on or neither on is a stop.
        next_state.forward = link_bits[`IRC_BIT_FORWARD]
                           & ~link_bits[`IRC_BIT_REVERSE];
        next_state.reverse = link_bits[`IRC_BIT_REVERSE]
                           & ~link_bits[`IRC_BIT_FORWARD];
        next_state.shutoff = link_bits[`IRC_BIT_OUTPUT_STOP];
        next_state.functions = decoded_functions;

        // Monitor words follow the core while the request is on.
        if (link_bits[`IRC_BIT_MONITOR]) begin
            next_state.monitor_words = monitor_data;
            next_state.monitor_valid = state.prev_bits[`IRC_BIT_MONITOR];
        end else begin
            next_state.monitor_valid = 1'b0;
        end

        // Set frequency echo while the volatile request is on.
        if (link_bits[`IRC_BIT_FREQ_RAM]) begin
            next_state.freq_echo = set_frequency_word;
        end

        // Pending requests are dropped if the master withdraws them.
        next_state.pending = (state.pending | accepted) & request_level;

        // Done flags fall with their request bits.
        if (!link_bits[`IRC_BIT_FREQ_RAM]) begin
            next_state.ram_done = 1'b0;
        end
        if (!link_bits[`IRC_BIT_FREQ_EEPROM]) begin
            next_state.ee_done = 1'b0;
        end
        if (!link_bits[`IRC_BIT_INSTR_EXEC]) begin
            next_state.instr_done = 1'b0;
        end

        // Request engine: one storage or instruction job at a time.
        unique case (state.fsm)
            irc_pkg::IRC_IDLE: begin
                next_state.slot = '0;
                if (next_state.pending[0]) begin
                    next_state.freq_data = set_frequency_word;
                    next_state.pending[0] = 1'b0;
                    next_state.fsm = irc_pkg::IRC_RAM_WRITE;
                end else if (next_state.pending[1]) begin
                    next_state.freq_data = set_frequency_word;
                    next_state.pending[1] = 1'b0;
                    next_state.fsm = irc_pkg::IRC_RAM_WRITE;
                end else if (next_state.pending[2]) begin
                    next_state.pending[2] = 1'b0;
                    next_state.fsm = irc_pkg::IRC_INSTR_ISSUE;
                end
            end
            irc_pkg::IRC_RAM_WRITE: begin
                if (ram_write_ack) begin
                    if (link_bits[`IRC_BIT_FREQ_EEPROM] && !state.ram_done
                        && !link_bits[`IRC_BIT_FREQ_RAM]) begin
                        next_state.fsm = irc_pkg::IRC_EE_WRITE;
                    end else begin
                        next_state.ram_done = link_bits[`IRC_BIT_FREQ_RAM];
                        next_state.fsm = irc_pkg::IRC_IDLE;
                    end
                end
            end
            irc_pkg::IRC_EE_WRITE: begin
                if (eeprom_write_ack) begin
                    next_state.ee_done = link_bits[`IRC_BIT_FREQ_EEPROM];
                    next_state.fsm = irc_pkg::IRC_IDLE;
                end
            end
            irc_pkg::IRC_INSTR_ISSUE: begin
                next_state.fsm = irc_pkg::IRC_INSTR_WAIT;
            end
            irc_pkg::IRC_INSTR_WAIT: begin
                if (instr_ack) begin
                    if (state.slot == SW'(SLOTS - 1)) begin
                        next_state.instr_done = link_bits[`IRC_BIT_INSTR_EXEC];
                        next_state.fsm = irc_pkg::IRC_IDLE;
                    end else begin
                        next_state.slot = state.slot + SW'(1);
                        next_state.fsm = irc_pkg::IRC_INSTR_ISSUE;
                    end
                end
            end
            default: begin
                next_state.fsm = irc_pkg::IRC_IDLE;
            end
        endcase

        // Initial setup count, then ready until a protective trip.
        if (state.init_count != IW'(INIT_CYCLES)) begin
            next_state.init_count = state.init_count + IW'(1);
        end else if (!state.error_status) begin
            next_state.station_ready = 1'b1;
        end

        // Error reset only acts while a fault is present.
        if (link_bits[`IRC_BIT_ERROR_RESET] && !state.prev_bits[`IRC_BIT_ERROR_RESET]
            && state.error_status && inverter_fault) begin
            next_state.reset_pulse  = 1'b1;
            next_state.error_status = 1'b0;
        end

        // A new trip sets the flag and wins over a reset in the same cycle.
        if (inverter_fault && !state.prev_fault) begin
            next_state.error_status  = 1'b1;
            next_state.station_ready = 1'b0;
        end
    end

    // Register the whole state; the enable freezes everything.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state              <= '0;
            state.source_mask  <= `IRC_SOURCE_RESET;
            state.extended     <= `IRC_EXTENDED_RESET;
            state.assign_codes <= {`IRC_ASSIGN_HI_RESET, `IRC_ASSIGN_LO_RESET};
            state.fsm          <= irc_pkg::IRC_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Outputs from the state register; instr_code selects the current slot's input word.
    assign reg_rdata                  = state.rdata;
    assign monitoring_valid_flag      = state.monitor_valid;
    assign freq_volatile_done_flag    = state.ram_done;
    assign freq_nonvolatile_done_flag = state.ee_done;
    assign instruction_exec_done_flag = state.instr_done;
    assign error_status_flag          = state.error_status;
    assign station_ready_flag         = state.station_ready;
    assign monitor_value_word         = state.monitor_words;
    assign freq_echo_word             = state.freq_echo;
    assign forward_run                = state.forward;
    assign reverse_run                = state.reverse;
    assign output_shutoff_function    = state.shutoff;
    assign terminal_function          = state.functions;
    assign inverter_reset             = state.reset_pulse;
    assign core_freq_data             = state.freq_data;
    assign ram_write_req              = state.fsm == irc_pkg::IRC_RAM_WRITE;
    assign eeprom_write_req           = state.fsm == irc_pkg::IRC_EE_WRITE;
    assign instr_req                  = state.fsm == irc_pkg::IRC_INSTR_ISSUE;
    assign instr_code = instruction_code_word[state.slot*WORD_W +: WORD_W];

endmodule

/* hdl/irc_params.svh */
/*
 * Constants of the remote command handler.
 * Assumes inclusion by its bare name from any file that needs them.
 */
`ifndef IRC_PARAMS_SVH
`define IRC_PARAMS_SVH

// Register byte offsets on the plain register port.
`define IRC_ADDR_SOURCE       8'h00
`define IRC_ADDR_EXTENDED     8'h04
`define IRC_ADDR_ASSIGN_LO    8'h08
`define IRC_ADDR_ASSIGN_HI    8'h0c
`define IRC_ADDR_STATUS       8'h10
`define IRC_ADDR_FIXED_ASSIGN 8'h14

// Reset values.
`define IRC_SOURCE_RESET      9'h000
`define IRC_EXTENDED_RESET    8'h00
`define IRC_ASSIGN_LO_RESET   32'h76543210
`define IRC_ASSIGN_HI_RESET   4'h8

// Positions of the master-to-device bits for station 1.
`define IRC_BIT_FORWARD       0
`define IRC_BIT_REVERSE       1
`define IRC_BIT_ASSIGN_FIRST  2
`define IRC_BIT_OUTPUT_STOP   9
`define IRC_BIT_SELF_HOLD     10
`define IRC_BIT_RESET_FUNC    11
`define IRC_BIT_MONITOR       12
`define IRC_BIT_FREQ_RAM      13
`define IRC_BIT_FREQ_EEPROM   14
`define IRC_BIT_INSTR_EXEC    15
`define IRC_BIT_ERROR_RESET   26

// Initial setup time after reset, in clock cycles.
`define IRC_INIT_CYCLES       100

`endif

/* hdl/irc_pkg.sv */
/*
 * Types shared by the remote command handler files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package irc_pkg;

    // Request engine states.
    typedef enum logic [2:0] {
        IRC_IDLE       = 3'b000,
        IRC_RAM_WRITE  = 3'b001,
        IRC_EE_WRITE   = 3'b010,
        IRC_INSTR_ISSUE = 3'b011,
        IRC_INSTR_WAIT = 3'b100
    } irc_state_t;

endpackage

/* hdl/irc_reply_mem.sv */
/*
 * Reply code memory, one word per slot, registered read.
 * Assumes a single clock and one write port and one read port.
 */
`timescale 1ns/1ps
module irc_reply_mem #(
    parameter int DEPTH = 6,
    parameter int WIDTH = 16
) (
    // Clock, enable and reset.
    input  wire logic                     clock,
    input  wire logic                     ce,
    input  wire logic                     resetn,
    // Write port.
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata,
    // Read port, data one cycle after the address.
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [WIDTH-1:0]         rdata
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rdata;
    } irc_mem_state_t;

    irc_mem_state_t state;
    irc_mem_state_t next_state;

    // Store the written word and register the addressed word.
    always_comb begin
        next_state = state;
        if (we) begin
            next_state.mem[waddr] = wdata;
        end
        next_state.rdata = state.mem[raddr];
    end

    // All words read as zero, meaning success, after reset.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;

endmodule

/* tb/irc_asserts.sv */
/* Port checker for irc_handler.
   Assumes ce stays high and one clock. */
`timescale 1ns/1ps
module irc_asserts #(parameter int WORD_W = 16) (
    // Clock, reset, master side and core side.
    input wire logic              clock,
    input wire logic              resetn,
    input wire logic [31:0]       link_bits,
    input wire logic [WORD_W-1:0] set_frequency_word,
    input wire logic              ram_write_ack,
    input wire logic              inverter_fault,
    // Outputs under watch.
    input wire logic [WORD_W-1:0] freq_echo_word,
    input wire logic              monitoring_valid_flag,
    input wire logic              freq_volatile_done_flag,
    input wire logic              error_status_flag,
    input wire logic              forward_run,
    input wire logic              reverse_run,
    input wire logic              output_shutoff_function
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_fwd_run:
    assert property (link_bits[1:0] == 2'h1 |=> forward_run) else $error("fwd");
    a_rev_run:
    assert property (link_bits[1:0] == 2'h2 |=> reverse_run) else $error("rev");
    a_both_stop:
    assert property (&link_bits[1:0] |=> !(forward_run || reverse_run))
        else $error("both");
    a_out_stop:
    assert property (link_bits[9] |=> output_shutoff_function) else $error("mrs");
    a_mon_clear:
    assert property (!link_bits[12] |=> !monitoring_valid_flag) else $error("mv");
    a_echo_freq:
    assert property (link_bits[13] |=> freq_echo_word == $past(set_frequency_word))
        else $error("echo");
    a_ram_done:
    assert property ($rose(freq_volatile_done_flag) |-> $past(ram_write_ack))
        else $error("ram");
    a_err_set:
    assert property ($rose(inverter_fault) |=> error_status_flag) else $error("err");
    // Main scenarios reached.
    cover property ($rose(monitoring_valid_flag));
    cover property ($rose(freq_volatile_done_flag));
    cover property ($rose(error_status_flag));
endmodule
bind irc_handler irc_asserts #(.WORD_W(WORD_W)) chk (.*);

/* tb/irc_core_model.sv */
/* Inverter core stand-in: acks stores, runs instruction codes.
   Assumes the handler's clock; codes with bit 15 set fail. */
`timescale 1ns/1ps
module irc_core_model (
    // Clock, reset and store handshakes.
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        ram_write_req,
    input  wire logic        eeprom_write_req,
    output logic             ram_write_ack,
    output logic             eeprom_write_ack,
    // Instruction handshake.
    input  wire logic        instr_req,
    input  wire logic [15:0] instr_code,
    output logic             instr_ack,
    output logic [15:0]      instr_result
);
    logic [2:0]  wait_cnt;
    logic [1:0]  exec_cnt;
    logic [15:0] held_code;
    // A RAM store takes four cycles, the EEPROM store after it three; a code takes three, then one ack pulse.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {wait_cnt, ram_write_ack, eeprom_write_ack} <= '0;
            {exec_cnt, instr_ack, held_code} <= '0;
        end else begin
            ram_write_ack <= ram_write_req && wait_cnt == 3'h3;
            eeprom_write_ack <= eeprom_write_req && wait_cnt == 3'h3;
            wait_cnt <= (ram_write_req || eeprom_write_req) &&
                        wait_cnt != 3'h3 ? wait_cnt + 3'h1 : 3'h0;
            instr_ack <= exec_cnt == 2'h1;
            exec_cnt <= instr_req ? 2'h2 : exec_cnt - {1'b0, |exec_cnt};
            if (instr_req) held_code <= instr_code;
        end
    end
    // Result is junk outside the ack cycle.
    assign instr_result = !instr_ack ? ~held_code :
                          held_code[15] ? held_code : 16'h0000;
endmodule

/* tb/tb_top.sv */
/* Self-checking bench for irc_handler.
   Assumes the core stand-in; the bench plays the master. */
`timescale 1ns/1ps
module tb_top;
    logic clock, ce, resetn, reg_write, reg_read, inverter_fault;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, link_bits;
    logic [15:0] set_frequency_word, freq_echo_word, reply_code_word;
    logic [15:0] core_freq_data, instr_code, instr_result, terminal_function;
    logic [95:0] instruction_code_word, monitor_value_word, monitor_data;
    logic [2:0] reply_index;
    logic monitoring_valid_flag, freq_volatile_done_flag, error_status_flag;
    logic freq_nonvolatile_done_flag, instruction_exec_done_flag;
    logic station_ready_flag, forward_run, reverse_run, inverter_reset;
    logic output_shutoff_function, ram_write_req, ram_write_ack, instr_req;
    logic eeprom_write_req, eeprom_write_ack, instr_ack;
    int error_cnt, n_checks, n_instr;
    irc_handler #(.INIT_CYCLES(4)) dut (.*);
    irc_core_model core (.*);
    // Clock and count of issued codes.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) if (instr_req === 1'b1) n_instr++;
    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic bits(input logic [31:0] v, input int n);
        @(posedge clock);
        link_bits <= v;
        cyc(n);
    endtask
    task automatic waitf(ref logic f);
        for (int i = 0; i < 60 && f !== 1'b1; i++) cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge clock);
        reg_read <= 1'b0;
        #1 check(reg_rdata, e);
    endtask
    task automatic t_run();
        logic [31:0] v[4] = '{32'h1, 32'h2, 32'h3, 32'h200};
        logic [2:0] e[4] = '{3'h4, 3'h2, 3'h0, 3'h1};
        for (int i = 0; i < 4; i++) begin
            bits(v[i], 2);
            check({forward_run, reverse_run, output_shutoff_function}, e[i]);
        end
        for (int k = 0; k < 9; k++) begin
            bits(32'h1 << (k < 7 ? k + 2 : k + 3), 2);
            check(terminal_function, 16'h1 << k);
        end
    endtask
    task automatic t_mon();
        monitor_data <= {6{16'h1357}};
        bits(32'h1000, 0);
        waitf(monitoring_valid_flag);
        check(monitor_value_word, {6{16'h1357}});
        monitor_data <= {6{16'h2468}};
        cyc(2);
        check(monitor_value_word, {6{16'h2468}});
    endtask
    task automatic t_freq(input int b, ref logic f, input logic [15:0] w);
        set_frequency_word <= w;
        bits(32'h1 << b, 0);
        waitf(f);
        check({f, core_freq_data}, {1'b1, w});
        bits(32'h0, 2);
        check(f, 1'b0);
    endtask
    task automatic t_instr();
        instruction_code_word <= {16'h0005, 16'h8004, {4{16'h0001}}};
        bits(32'h8000, 0);
        waitf(instruction_exec_done_flag);
        check(n_instr, 6);
        for (int i = 0; i < 6; i++) begin
            reply_index <= 3'(i);
            cyc(2);
            check(reply_code_word, i == 4 ? 16'h8004 : 16'h0);
        end
        bits(32'h0, 2);
        bits(32'h0000e000, 20);
        check({freq_nonvolatile_done_flag, instruction_exec_done_flag}, 0);
        check(freq_volatile_done_flag, 1'b1);
    endtask
    task automatic t_err();
        bits(32'h4000000, 3);
        check(inverter_reset, 1'b0);
        inverter_fault <= 1'b1;
        bits(32'h0, 2);
        check({error_status_flag, station_ready_flag}, 2'h2);
        bits(32'h4000000, 0);
        waitf(inverter_reset);
        cyc(1);
        check({inverter_reset, error_status_flag}, 2'h0);
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence after a five-cycle reset.
    initial begin
        {ce, resetn, reg_write, reg_read, inverter_fault, reply_index} = 8'h80;
        {reg_addr, reg_wdata, link_bits, set_frequency_word} = '0;
        {instruction_code_word, monitor_data} = '0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        cyc(3);
        check(station_ready_flag, 1'b0);
        cyc(3);
        check(station_ready_flag, 1'b1);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h76543210);
        rd(8'h14, 32'h0);
        t_run();
        t_mon();
        t_freq(13, freq_volatile_done_flag, 16'h1234);
        t_freq(14, freq_nonvolatile_done_flag, 16'h0bcd);
        t_instr();
        t_err();
        stop_test();
    end
    // Watchdog.
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
endmodule
